// file: core/stc_pkg.sv
// package: register map, field layout and constants for the 16-bit timer core
package stc_pkg;
    // register offsets (byte addresses, one aligned word each)
    localparam logic [7:0] OFS_COUNT_LO = 8'h00;
    localparam logic [7:0] OFS_COUNT_HI = 8'h04;
    localparam logic [7:0] OFS_CMPA_LO = 8'h08;
    localparam logic [7:0] OFS_CMPA_HI = 8'h0c;
    localparam logic [7:0] OFS_CMPB_LO = 8'h10;
    localparam logic [7:0] OFS_CMPB_HI = 8'h14;
    localparam logic [7:0] OFS_CAP_LO = 8'h18;
    localparam logic [7:0] OFS_CAP_HI = 8'h1c;
    localparam logic [7:0] OFS_CTRL_A = 8'h20;
    localparam logic [7:0] OFS_CTRL_B = 8'h24;
    localparam logic [7:0] OFS_FLAG = 8'h28;
    localparam logic [7:0] OFS_MASK = 8'h2c;
    localparam logic [7:0] OFS_POWER = 8'h30;

    // ctrl_b fields
    localparam int CS_LSB = 0;
    localparam int WGM_HI_LSB = 3;
    localparam int CAP_EDGE_BIT = 6;
    localparam int CAP_FILT_BIT = 7;
    // ctrl_a fields
    localparam int WGM_LO_LSB = 0;
    localparam int CAP_SRC_BIT = 2;

    // flag / mask bit positions
    localparam int FL_OVF = 0;
    localparam int FL_CMPA = 1;
    localparam int FL_CMPB = 2;
    localparam int FL_CAP = 5;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] POWER_RESET = 8'h01;
    localparam logic [15:0] VAL_BOTTOM = 16'h0000;
    localparam logic [15:0] VAL_MAX = 16'hffff;
    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;
    localparam int FILTER_LEN = 4;

    typedef enum logic [2:0] {
        STC_CS_STOP, STC_CS_DIV1, STC_CS_DIV8, STC_CS_DIV64,
        STC_CS_DIV256, STC_CS_DIV1024, STC_CS_EXT_FALL, STC_CS_EXT_RISE
    } stc_clksel_t;

    typedef struct packed {
        logic ovf;
        logic cmpa;
        logic cmpb;
        logic cap;
    } stc_events_t;
endpackage

// file: core/stc_tick.sv
// clock-select and prescaler: produces the one-cycle timer tick
`timescale 1ns/1ns
module stc_tick (
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic [2:0] clksel,
    input wire logic ext_pin_sync,
    output logic tick
);
    logic [9:0] prescale;
    logic ext_prev;
    logic next_tick;

    always_ff @(posedge clk) begin
        if (!rstn || !run) begin
            prescale <= 10'h000;
        end else begin
            prescale <= prescale + 10'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= ext_pin_sync;
        end
    end

    // idle when no source selected [R10]
    always_comb begin
        case (stc_pkg::stc_clksel_t'(clksel))
            stc_pkg::STC_CS_DIV1: next_tick = 1'b1;
            stc_pkg::STC_CS_DIV8: next_tick = (prescale[2:0] == 3'h7);
            stc_pkg::STC_CS_DIV64: next_tick = (prescale[5:0] == 6'h3f);
            stc_pkg::STC_CS_DIV256: next_tick = (prescale[7:0] == 8'hff);
            stc_pkg::STC_CS_DIV1024: next_tick = (prescale == 10'h3ff);
            stc_pkg::STC_CS_EXT_FALL: next_tick = ext_prev && !ext_pin_sync;
            stc_pkg::STC_CS_EXT_RISE: next_tick = !ext_prev && ext_pin_sync;
            default: next_tick = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            tick <= 1'b0;
        end else begin
            tick <= run && next_tick;
        end
    end

    a_stop_no_tick: assert property (@(posedge clk) disable iff (!rstn) // [R10]
        (clksel == 3'h0) |=> !tick)
        else $error("tick while no clock source selected");
endmodule

// file: core/stc_timer.sv
// 16-bit timer core with shared high-byte holding register, APB slave
`timescale 1ns/1ns
//
// Contract
// (R1) wide registers are 16 bits, reached as two separate byte accesses
// (R2) one 8-bit high-byte holding register shared by all wide registers
// (R3) low-byte write loads holding byte and written byte together
// (R4) low-byte read copies register high byte into holding register
// (R5) compare registers read both bytes directly, no holding register
// (R6) software writes high byte first, reads low byte first
// (R7) control registers are plain 8-bit, single access, no ordering
// (R8) every interrupt request is a flag bit, individually maskable
// (R9) four sources: overflow, compare A, compare B, capture
// (R10) tick from prescaler or external pin; idle with no source
// (R11) buffered compare values compared continuously; match sets flag
// (R12) capture pin or comparator edge stores count, optional filter; the code stores nothing while capture sets the ceiling (modes 8, 10, 12, 14)
// (R13) ceiling is fixed 0x00ff/0x01ff/0x03ff, compare A or capture
// (R14) compare A as ceiling in PWM: no output, value double buffered
// (R15) minimum is 0x0000, maximum is 0xffff
// (R16) timer runs only while power-down bit is zero
// (R17) software counter write wins over count or clear
// (R18) interrupt request only while flag and mask both set
module stc_timer (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_count_pin,
    input wire logic capture_input_pin,
    input wire logic comparator_out,
    output logic [1:0] compare_output_pins,
    output logic irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] timer_count;
    logic [15:0] compare_a_value, compare_b_value;
    logic [15:0] cmpa_active, cmpb_active;
    logic [15:0] capture_value_reg;
    logic [7:0] hold_hi;
    logic [7:0] ctrl_a, ctrl_b;
    logic [7:0] timer_flag_reg, timer_mask_reg;
    logic timer_power_down_bit;
    logic [1:0] ext_sync, icp_sync, acmp_sync;
    logic timer_tick;
    logic [3:0] wgm;
    logic [15:0] top_val;
    logic at_top, pwm_mode, count_down;
    logic [3:0] filt_sr;
    logic cap_level, cap_prev, cap_edge;
    stc_pkg::stc_events_t ev;

    logic acc, wr, rd;
    logic [7:0] wbyte;

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign wbyte = pwdata[7:0];
    assign wgm = {ctrl_b[stc_pkg::WGM_HI_LSB +: 2], ctrl_a[stc_pkg::WGM_LO_LSB +: 2]};

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ext_sync <= 2'b00;
            icp_sync <= 2'b00;
            acmp_sync <= 2'b00;
        end else begin
            ext_sync <= {ext_sync[0], external_count_pin};
            icp_sync <= {icp_sync[0], capture_input_pin};
            acmp_sync <= {acmp_sync[0], comparator_out};
        end
    end

    stc_tick u_tick (
        .clk(clk),
        .rstn(rstn),
        .run(!timer_power_down_bit), // [R16]
        .clksel(ctrl_b[stc_pkg::CS_LSB +: 3]),
        .ext_pin_sync(ext_sync[1]),
        .tick(timer_tick)
    );

    // ------------------------------------------------------------
    // ceiling selection
    // ------------------------------------------------------------
    always_comb begin
        case (wgm)
            4'h1, 4'h5: top_val = stc_pkg::TOP_8BIT; // [R13]
            4'h2, 4'h6: top_val = stc_pkg::TOP_9BIT;
            4'h3, 4'h7: top_val = stc_pkg::TOP_10BIT;
            4'h4, 4'h9, 4'hb, 4'hf: top_val = cmpa_active;
            4'h8, 4'ha, 4'hc, 4'he: top_val = capture_value_reg;
            default: top_val = stc_pkg::VAL_MAX; // [R15]
        endcase
    end

    // modes other than normal (0), the two clear-on-match ones (4, 12) and mode 13 are PWM
    assign pwm_mode = !(wgm == 4'h0 || wgm == 4'h4 || wgm == 4'hc || wgm == 4'hd);
    assign at_top = (timer_count == top_val);

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    // phase-correct modes (1-3, 8-11) count up then down
    logic phase_mode;
    assign phase_mode = (wgm[3:2] == 2'b00 && wgm != 4'h0) || (wgm[3:2] == 2'b10);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            timer_count <= stc_pkg::VAL_BOTTOM;
            count_down <= 1'b0;
        end else if (wr && hit(paddr, stc_pkg::OFS_COUNT_LO)) begin
            timer_count <= {hold_hi, wbyte}; // [R3] [R17]
        end else if (timer_tick) begin
            if (phase_mode) begin
                if (!count_down && at_top) begin
                    count_down <= 1'b1;
                    timer_count <= timer_count - 16'h0001;
                end else if (count_down && timer_count == stc_pkg::VAL_BOTTOM) begin
                    count_down <= 1'b0;
                    timer_count <= timer_count + 16'h0001;
                end else begin
                    timer_count <= count_down ? timer_count - 16'h0001
                                              : timer_count + 16'h0001;
                end
            end else if (at_top) begin
                timer_count <= stc_pkg::VAL_BOTTOM;
                count_down <= 1'b0;
            end else begin
                timer_count <= timer_count + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // compare buffers: immediate in non-PWM, at top/bottom in PWM
    // ------------------------------------------------------------
    logic buf_load;
    assign buf_load = !pwm_mode ||
        (timer_tick && (phase_mode ? at_top : timer_count == stc_pkg::VAL_BOTTOM));

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cmpa_active <= stc_pkg::VAL_BOTTOM;
            cmpb_active <= stc_pkg::VAL_BOTTOM;
        end else if (buf_load) begin
            cmpa_active <= compare_a_value; // [R14]
            cmpb_active <= compare_b_value;
        end
    end

    // ------------------------------------------------------------
    // input capture with optional noise filter
    // ------------------------------------------------------------
    logic cap_src;
    assign cap_src = ctrl_a[stc_pkg::CAP_SRC_BIT] ? acmp_sync[1] : icp_sync[1];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            filt_sr <= 4'h0;
            cap_level <= 1'b0;
            cap_prev <= 1'b0;
        end else begin
            filt_sr <= {filt_sr[2:0], cap_src};
            // filter needs stc_pkg::FILTER_LEN equal samples before a level change
            if (!ctrl_b[stc_pkg::CAP_FILT_BIT]) begin
                cap_level <= cap_src;
            end else if (filt_sr == 4'hf) begin
                cap_level <= 1'b1;
            end else if (filt_sr == 4'h0) begin
                cap_level <= 1'b0;
            end
            cap_prev <= cap_level;
        end
    end

    assign cap_edge = !timer_power_down_bit && (ctrl_b[stc_pkg::CAP_EDGE_BIT]
        ? (cap_level && !cap_prev) : (!cap_level && cap_prev)); // [R12]

    // ------------------------------------------------------------
    // events
    // ------------------------------------------------------------
    always_comb begin
        ev.ovf = timer_tick && (phase_mode ? (count_down && timer_count == 16'h0001)
                                           : (pwm_mode ? at_top
                                                       : timer_count == stc_pkg::VAL_MAX));
        ev.cmpa = timer_tick && (timer_count == cmpa_active); // [R11]
        ev.cmpb = timer_tick && (timer_count == cmpb_active); // [R11]
        ev.cap = cap_edge;
    end

    // ------------------------------------------------------------
    // software registers and capture register
    // ------------------------------------------------------------
    logic cap_is_top;
    assign cap_is_top = (top_val == capture_value_reg) && wgm[3] && !wgm[0];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            capture_value_reg <= stc_pkg::VAL_BOTTOM;
        end else if (wr && hit(paddr, stc_pkg::OFS_CAP_LO)) begin
            capture_value_reg <= {hold_hi, wbyte}; // [R3]
        end else if (ev.cap && !cap_is_top) begin
            capture_value_reg <= timer_count; // [R12]
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            compare_a_value <= stc_pkg::VAL_BOTTOM;
            compare_b_value <= stc_pkg::VAL_BOTTOM;
            ctrl_a <= stc_pkg::CTRL_RESET;
            ctrl_b <= stc_pkg::CTRL_RESET;
            timer_mask_reg <= stc_pkg::CTRL_RESET;
            timer_power_down_bit <= stc_pkg::POWER_RESET[0];
        end else if (wr) begin
            if (hit(paddr, stc_pkg::OFS_CMPA_LO)) begin
                compare_a_value <= {hold_hi, wbyte}; // [R3] [R1]
            end else if (hit(paddr, stc_pkg::OFS_CMPB_LO)) begin
                compare_b_value <= {hold_hi, wbyte}; // [R3]
            end else if (hit(paddr, stc_pkg::OFS_CTRL_A)) begin
                ctrl_a <= wbyte; // [R7]
            end else if (hit(paddr, stc_pkg::OFS_CTRL_B)) begin
                ctrl_b <= wbyte; // [R7]
            end else if (hit(paddr, stc_pkg::OFS_MASK)) begin
                timer_mask_reg <= wbyte; // [R8]
            end else if (hit(paddr, stc_pkg::OFS_POWER)) begin
                timer_power_down_bit <= wbyte[0]; // [R16]
            end
        end
    end

    // shared high byte: written by any high-byte write, loaded by count and capture low reads
    always_ff @(posedge clk) begin
        if (!rstn) begin
            hold_hi <= 8'h00;
        end else if (wr && (hit(paddr, stc_pkg::OFS_COUNT_HI) || hit(paddr, stc_pkg::OFS_CMPA_HI)
                || hit(paddr, stc_pkg::OFS_CMPB_HI) || hit(paddr, stc_pkg::OFS_CAP_HI))) begin
            hold_hi <= wbyte; // [R2]
        end else if (rd && hit(paddr, stc_pkg::OFS_COUNT_LO)) begin
            hold_hi <= timer_count[15:8]; // [R4]
        end else if (rd && hit(paddr, stc_pkg::OFS_CAP_LO)) begin
            hold_hi <= capture_value_reg[15:8]; // [R4]
        end
    end

    // ------------------------------------------------------------
    // flags: set wins over write-one-to-clear
    // ------------------------------------------------------------
    logic [7:0] ev_bits, clr_bits;
    logic [7:0] next_mask;
    always_comb begin
        ev_bits = 8'h00;
        ev_bits[stc_pkg::FL_OVF] = ev.ovf; // [R9]
        ev_bits[stc_pkg::FL_CMPA] = ev.cmpa;
        ev_bits[stc_pkg::FL_CMPB] = ev.cmpb;
        ev_bits[stc_pkg::FL_CAP] = ev.cap;
        clr_bits = (wr && hit(paddr, stc_pkg::OFS_FLAG)) ? wbyte : 8'h00;
        // new mask too, so a cleared mask bit drops irq at once
        next_mask = (wr && hit(paddr, stc_pkg::OFS_MASK)) ? wbyte : timer_mask_reg;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            timer_flag_reg <= 8'h00;
        end else begin
            timer_flag_reg <= (timer_flag_reg & ~clr_bits) | ev_bits; // [R8]
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((timer_flag_reg & ~clr_bits) | ev_bits) & next_mask); // [R18]
        end
    end

    // ------------------------------------------------------------
    // compare outputs: toggle on match; A silent when it sets the ceiling in a PWM mode
    // ------------------------------------------------------------
    logic a_is_top;
    assign a_is_top = (wgm == 4'h4) || (wgm == 4'h9) || (wgm == 4'hb) || (wgm == 4'hf);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            compare_output_pins <= 2'b00;
        end else begin
            if (ev.cmpa && !(a_is_top && pwm_mode)) begin
                compare_output_pins[0] <= !compare_output_pins[0]; // [R14]
            end
            if (ev.cmpb) begin
                compare_output_pins[1] <= !compare_output_pins[1]; // [R11]
            end
        end
    end

    // ------------------------------------------------------------
    // APB read path; answers in the access cycle, no wait states
    // ------------------------------------------------------------
    logic [7:0] rbyte;
    logic mapped;
    always_comb begin
        rbyte = 8'h00;
        mapped = 1'b1;
        if (hit(paddr, stc_pkg::OFS_COUNT_LO)) begin
            rbyte = timer_count[7:0];
        end else if (hit(paddr, stc_pkg::OFS_COUNT_HI) || hit(paddr, stc_pkg::OFS_CAP_HI)) begin
            rbyte = hold_hi; // [R2]
        end else if (hit(paddr, stc_pkg::OFS_CMPA_LO)) begin
            rbyte = compare_a_value[7:0];
        end else if (hit(paddr, stc_pkg::OFS_CMPA_HI)) begin
            rbyte = compare_a_value[15:8]; // [R5]
        end else if (hit(paddr, stc_pkg::OFS_CMPB_LO)) begin
            rbyte = compare_b_value[7:0];
        end else if (hit(paddr, stc_pkg::OFS_CMPB_HI)) begin
            rbyte = compare_b_value[15:8]; // [R5]
        end else if (hit(paddr, stc_pkg::OFS_CAP_LO)) begin
            rbyte = capture_value_reg[7:0];
        end else if (hit(paddr, stc_pkg::OFS_CTRL_A)) begin
            rbyte = ctrl_a;
        end else if (hit(paddr, stc_pkg::OFS_CTRL_B)) begin
            rbyte = ctrl_b;
        end else if (hit(paddr, stc_pkg::OFS_FLAG)) begin
            rbyte = timer_flag_reg;
        end else if (hit(paddr, stc_pkg::OFS_MASK)) begin
            rbyte = timer_mask_reg;
        end else if (hit(paddr, stc_pkg::OFS_POWER)) begin
            rbyte = {7'h00, timer_power_down_bit};
        end else begin
            mapped = 1'b0;
        end
    end

    // registered answer: setup cycle prepares, access cycle presents
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable && !pwrite) ? {24'h000000, rbyte} : 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_low_write_load: assert property (@(posedge clk) disable iff (!rstn) // [R3]
        (wr && hit(paddr, stc_pkg::OFS_COUNT_LO)) |=> timer_count == $past({hold_hi, wbyte}))
        else $error("count low write did not load holding byte");
    a_low_read_latch: assert property (@(posedge clk) disable iff (!rstn) // [R4]
        (rd && hit(paddr, stc_pkg::OFS_COUNT_LO)) |=> hold_hi == $past(timer_count[15:8]))
        else $error("count low read did not latch high byte");
    a_cmp_direct: assert property (@(posedge clk) disable iff (!rstn) // [R5]
        (psel && !penable && !pwrite && hit(paddr, stc_pkg::OFS_CMPA_HI))
        |=> prdata[7:0] == $past(compare_a_value[15:8]))
        else $error("compare high read went through holding byte");
    a_flag_sticky: assert property (@(posedge clk) disable iff (!rstn) // [R8]
        ev.cmpa |=> timer_flag_reg[stc_pkg::FL_CMPA])
        else $error("compare match flag not set");
    a_irq_gate: assert property (@(posedge clk) disable iff (!rstn) // [R18]
        irq == |(timer_flag_reg & timer_mask_reg))
        else $error("interrupt not tied to flag and mask");
    a_power_hold: assert property (@(posedge clk) disable iff (!rstn) // [R16]
        (timer_power_down_bit && !wr) [*2] |=> $stable(timer_count))
        else $error("counter moved while powered down");
    a_ceiling_wrap: assert property (@(posedge clk) disable iff (!rstn) // [R13]
        (timer_tick && at_top && !phase_mode && !wr) |=> timer_count == stc_pkg::VAL_BOTTOM)
        else $error("counter did not wrap at ceiling");
    a_capture_store: assert property (@(posedge clk) disable iff (!rstn) // [R12]
        (ev.cap && !cap_is_top && !wr) |=> capture_value_reg == $past(timer_count))
        else $error("capture did not store count");
    a_ctrl_single: assert property (@(posedge clk) disable iff (!rstn) // [R7]
        (wr && hit(paddr, stc_pkg::OFS_CTRL_B)) |=> ctrl_b == $past(wbyte))
        else $error("control write not taken in one access");
    a_apb_ready: assert property (@(posedge clk) disable iff (!rstn)
        (psel && !penable) |=> pready)
        else $error("no answer in access cycle");
endmodule

// file: bench/stc_pin_model.sv
// far-side pin model: count, capture and comparator inputs of the timer
`timescale 1ns/1ns
module stc_pin_model (
    input wire logic clk,
    output logic external_count_pin,
    output logic capture_input_pin,
    output logic comparator_out
);
    initial begin
        external_count_pin = 1'b0;
        capture_input_pin = 1'b0;
        comparator_out = 1'b0;
    end
    // levels held 4 cycles so the synchroniser never drops an edge
    task automatic pulse_ext(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            external_count_pin <= ~external_count_pin;
            repeat (4) @(posedge clk);
            external_count_pin <= ~external_count_pin;
        end
    endtask
    // rising edge held long enough to pass the noise filter
    task automatic cap_edge(input logic cmp);
        @(posedge clk);
        if (cmp) comparator_out <= 1'b1;
        else capture_input_pin <= 1'b1;
    endtask
endmodule

// file: bench/sixteen_bit_timer_core_access_test.sv
// self-checking bench for the 16-bit timer core over apb
`timescale 1ns/1ns
module sixteen_bit_timer_core_access_test;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, irq, ecp, cip, cmo, err;
    logic [7:0] paddr, rd;
    logic [31:0] pwdata, prdata;
    logic [1:0] cop;
    logic [15:0] v, w;
    int error_cnt, check_count, seed;
    stc_timer uut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_count_pin(ecp), .capture_input_pin(cip), .comparator_out(cmo),
        .compare_output_pins(cop), .irq(irq));
    stc_pin_model pins (.clk(clk), .external_count_pin(ecp), .capture_input_pin(cip),
        .comparator_out(cmo));
    always #50 clk = ~clk;
    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // ------------------------------------------------------------
    // apb master: request held until pready is seen at a rising edge
    // ------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (pready !== 1'b1) begin error_cnt++; stop_test(); end
    endtask
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        xfer(1'b1, a + 8'h04, d[15:8]);
        xfer(1'b1, a, d[7:0]);
    endtask
    task automatic rd16(input logic [7:0] a, output logic [15:0] d);
        xfer(1'b0, a, 8'h00);
        d[7:0] = rd;
        xfer(1'b0, a + 8'h04, 8'h00);
        d[15:8] = rd;
    endtask
    task automatic poll(input int b);
        int n;
        n = 0;
        do begin xfer(1'b0, stc_pkg::OFS_FLAG, 8'h00); n++; end while (rd[b] !== 1'b1 && n < 300);
        chk(16'(rd[b]), 16'h0001);
        if (n >= 300) stop_test();
    endtask
    initial begin
        clk = 0; rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        seed = 53; error_cnt = 0; check_count = 0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        xfer(1'b0, stc_pkg::OFS_POWER, 8'h00);
        chk(16'(rd), 16'(stc_pkg::POWER_RESET));
        xfer(1'b1, stc_pkg::OFS_CTRL_B, 8'h01);
        repeat (10) @(posedge clk);
        rd16(stc_pkg::OFS_COUNT_LO, w);
        chk(w, stc_pkg::VAL_BOTTOM);
        xfer(1'b1, stc_pkg::OFS_CTRL_B, 8'h00);
        xfer(1'b1, stc_pkg::OFS_POWER, 8'h00);
        xfer(1'b0, 8'h34, 8'h00);
        chk({7'h00, err, rd}, 16'h0100);
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? stc_pkg::VAL_MAX : (i == 1) ? stc_pkg::VAL_BOTTOM : 16'($random(seed));
            wr16(stc_pkg::OFS_COUNT_LO, v);
            rd16(stc_pkg::OFS_COUNT_LO, w);
            chk(w, v);
            xfer(1'b1, stc_pkg::OFS_CTRL_B, v[7:0] & 8'hd8);
            xfer(1'b0, stc_pkg::OFS_CTRL_B, 8'h00);
            chk(16'(rd), 16'(v[7:0] & 8'hd8));
        end
        // one high byte feeds two compare registers
        v = 16'($random(seed));
        wr16(stc_pkg::OFS_COUNT_LO, {~v[15:8], 8'h00});
        xfer(1'b1, stc_pkg::OFS_CMPB_HI, v[15:8]);
        xfer(1'b1, stc_pkg::OFS_CMPB_LO, v[7:0]);
        xfer(1'b1, stc_pkg::OFS_CMPA_LO, ~v[7:0]);
        xfer(1'b0, stc_pkg::OFS_COUNT_LO, 8'h00);
        rd16(stc_pkg::OFS_CMPB_LO, w);
        chk(w, v);
        xfer(1'b0, stc_pkg::OFS_CMPA_HI, 8'h00);
        chk(16'(rd), 16'(v[15:8]));
        // compare match with its request masked, then unmasked and cleared
        wr16(stc_pkg::OFS_CMPA_LO, 16'h0020);
        xfer(1'b1, stc_pkg::OFS_CMPB_LO, 8'h10);
        wr16(stc_pkg::OFS_COUNT_LO, 16'h0000);
        xfer(1'b1, stc_pkg::OFS_CTRL_B, 8'h01);
        poll(stc_pkg::FL_CMPA);
        xfer(1'b1, stc_pkg::OFS_CTRL_B, 8'h00);
        chk({13'h0000, cop, irq}, 16'h0006);
        rd16(stc_pkg::OFS_COUNT_LO, v);
        rd16(stc_pkg::OFS_COUNT_LO, w);
        chk(w, v);
        xfer(1'b1, stc_pkg::OFS_MASK, 8'h02);
        @(posedge clk);
        chk(16'(irq), 16'h0001);
        xfer(1'b1, stc_pkg::OFS_FLAG, 8'h02);
        @(posedge clk);
        chk(16'(irq), 16'h0000);
        // overflow through max
        xfer(1'b1, stc_pkg::OFS_MASK, 8'h01);
        wr16(stc_pkg::OFS_COUNT_LO, 16'hfffd);
        xfer(1'b1, stc_pkg::OFS_CTRL_B, 8'h01);
        poll(stc_pkg::FL_OVF);
        xfer(1'b1, stc_pkg::OFS_CTRL_B, 8'h00);
        chk(16'(irq), 16'h0001);
        xfer(1'b1, stc_pkg::OFS_FLAG, 8'hff);
        @(posedge clk);
        chk(16'(irq), 16'h0000);
        // compare a as ceiling
        wr16(stc_pkg::OFS_CMPA_LO, 16'h0005);
        wr16(stc_pkg::OFS_COUNT_LO, 16'h0000);
        xfer(1'b1, stc_pkg::OFS_CTRL_B, 8'h09);
        repeat (40) @(posedge clk);
        xfer(1'b1, stc_pkg::OFS_CTRL_B, 8'h08);
        rd16(stc_pkg::OFS_COUNT_LO, w);
        chk(16'(w <= 16'h0005), 16'h0001);
        // external pin, both edges
        for (int i = 0; i < 2; i++) begin
            wr16(stc_pkg::OFS_COUNT_LO, 16'h0000);
            xfer(1'b1, stc_pkg::OFS_CTRL_B, 8'h07 - 8'(i));
            pins.pulse_ext(5);
            repeat (8) @(posedge clk);
            xfer(1'b1, stc_pkg::OFS_CTRL_B, 8'h00);
            rd16(stc_pkg::OFS_COUNT_LO, w);
            chk(w, 16'h0005);
        end
        // capture from pin, then from comparator
        for (int i = 0; i < 2; i++) begin
            v = 16'($random(seed));
            wr16(stc_pkg::OFS_COUNT_LO, v);
            xfer(1'b1, stc_pkg::OFS_CTRL_A, 8'(i) << 2);
            xfer(1'b1, stc_pkg::OFS_CTRL_B, 8'h40 | (8'(i) << 7));
            pins.cap_edge(1'(i));
            poll(stc_pkg::FL_CAP);
            xfer(1'b1, stc_pkg::OFS_FLAG, 8'h20);
            rd16(stc_pkg::OFS_CAP_LO, w);
            chk(w, v);
        end
        stop_test();
    end
endmodule
